// file: pllcfg_chk.sv
// pllcfg_chk.sv - assertions on the ports of pllcfg_decoder
// assumes strap and word change only while reset is low
`timescale 1ns/10ps
module pllcfg_chk (
    // clock, reset and strap
    input wire clk_i,
    input wire rst_b_i,
    input wire usb_variant_i,
    // apb request
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    // apb answer and decoded settings
    input wire pready_o,
    input wire pslverr_o,
    input wire usb_pll_bypass_o,
    input wire cfg_valid_o,
    input wire [8:0] sys_pll_out_div_o,
    input wire [4:0] sys_pll_mult_o,
    input wire [2:0] sys_pll_in_div_sel_o,
    input wire [3:0] usb_pll_in_div_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    a_odiv_legal: assert property (cfg_valid_o |-> $onehot(sys_pll_out_div_o)
        && sys_pll_out_div_o != 9'h080) else $error("bad output divisor");
    a_mult_legal: assert property (cfg_valid_o |->
        sys_pll_mult_o inside {[5'h0f:5'h15], 5'h18}) else $error("bad multiplier");
    a_uidiv_legal: assert property (cfg_valid_o && usb_variant_i |->
        usb_pll_in_div_o inside {[4'h1:4'h6], 4'ha, 4'hc}) else $error("bad usb divider");
    a_nonusb_force: assert property (cfg_valid_o && !usb_variant_i |->
        usb_pll_bypass_o && usb_pll_in_div_o == 4'h1) else $error("usb fields active");
    a_hold_stable: assert property (cfg_valid_o && $past(cfg_valid_o) |->
        $stable({sys_pll_out_div_o, sys_pll_mult_o, sys_pll_in_div_sel_o,
        usb_pll_bypass_o, usb_pll_in_div_o})) else $error("settings changed");
    a_valid_soon: assert property ($rose(rst_b_i) |-> ##[1:6] cfg_valid_o)
        else $error("capture late");
    a_ready_next: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
    a_write_err: assert property (psel_i && !penable_i && pwrite_i |=> pslverr_o)
        else $error("write not refused");
endmodule // pllcfg_chk

bind pllcfg_decoder pllcfg_chk u_chk (.*);

// file: pllcfg_decoder.v
// pllcfg_decoder.v - pll configuration word decoder with apb read port
// assumes the non-volatile word is stable on cfg_word_i around reset release
// decoded settings are registered and fixed until the next pin reset
`timescale 1ns/10ps
`include "pllcfg_regs.vh"
module pllcfg_decoder (
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // variant strap and non-volatile word
    input wire usb_variant_i,
    input wire [31:0] cfg_word_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // decoded clock generator settings
    output reg [8:0] sys_pll_out_div_o,
    output reg [4:0] sys_pll_mult_o,
    output reg [2:0] sys_pll_in_div_sel_o,
    output reg usb_pll_bypass_o,
    output reg [3:0] usb_pll_in_div_o,
    output reg cfg_valid_o,
    output reg rsvd_err_o
);
    // ----------------------------------------
    // decode functions
    // ----------------------------------------
    function [8:0] odiv_f;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: odiv_f = 9'h001;
                3'h1: odiv_f = 9'h002;
                3'h2: odiv_f = 9'h004;
                3'h3: odiv_f = 9'h008;
                3'h4: odiv_f = 9'h010;
                3'h5: odiv_f = 9'h020;
                3'h6: odiv_f = 9'h040;
                // no code gives 128, the top code jumps to 256
                default: odiv_f = 9'h100;
            endcase
        end
    endfunction

    function [4:0] mul_f;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: mul_f = 5'h0f;
                3'h1: mul_f = 5'h10;
                3'h2: mul_f = 5'h11;
                3'h3: mul_f = 5'h12;
                3'h4: mul_f = 5'h13;
                3'h5: mul_f = 5'h14;
                3'h6: mul_f = 5'h15;
                // the top code jumps to 24, it is not 15 plus seven
                default: mul_f = 5'h18;
            endcase
        end
    endfunction

    function [3:0] uidiv_f;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: uidiv_f = 4'h1;
                3'h1: uidiv_f = 4'h2;
                3'h2: uidiv_f = 4'h3;
                3'h3: uidiv_f = 4'h4;
                3'h4: uidiv_f = 4'h5;
                3'h5: uidiv_f = 4'h6;
                3'h6: uidiv_f = 4'ha;
                default: uidiv_f = 4'hc;
            endcase
        end
    endfunction

    // every reserved bit must read back as one
    function rsvd_ok_f;
        input [31:0] w;
        begin
            rsvd_ok_f = ((w & `PLLCFG_RSVD_MASK) == `PLLCFG_RSVD_MASK);
        end
    endfunction

    // readback layout of the decoded settings, exactly one word wide
    function [31:0] dec_pack_f;
        input [8:0] odiv;
        input [3:0] uidiv;
        input [4:0] mul;
        input [2:0] idiv;
        begin
            dec_pack_f = {7'h00, odiv, 2'b00, uidiv, 2'b00, mul, idiv};
        end
    endfunction

    // readback layout of the status flags
    function [31:0] stat_pack_f;
        input usb_var;
        input bypass;
        input rsvd_err;
        input valid;
        begin
            stat_pack_f = {28'h000_0000, usb_var, bypass, rsvd_err, valid};
        end
    endfunction

    // ----------------------------------------
    // reset release and one-shot capture
    // ----------------------------------------
    reg [1:0] rst_sync_q;
    wire rst_n;
    reg captured_q;
    reg usb_var_q;
    wire [31:0] word;
    wire load;

    // pin reset leaves through two flops so all flops release on one edge
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // only one load per power-on; nothing later can rewrite it
    assign load = !captured_q;

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            captured_q <= 1'b0;
        end else if (load) begin
            captured_q <= 1'b1;
        end
    end

    // strap is taken with the word so a later strap change is ignored
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            usb_var_q <= 1'b0;
        end else if (load) begin
            usb_var_q <= usb_variant_i;
        end
    end

    // ----------------------------------------
    // captured word, kept in its own store
    // ----------------------------------------
    pllcfg_word_store u_store (
        .clk_i(clk_i),
        .rst_b_i(rst_n),
        .load_i(load),
        .word_i(cfg_word_i),
        .word_o(word)
    );

    // ----------------------------------------
    // next values of the decoded settings
    // ----------------------------------------
    reg [8:0] out_div_d;
    reg [4:0] mult_d;
    reg [2:0] in_div_sel_d;
    reg usb_bypass_d;
    reg [3:0] usb_in_div_d;
    reg rsvd_err_d;

    always @* begin
        out_div_d = odiv_f(word[`PLLCFG_ODIV_MSB:`PLLCFG_ODIV_LSB]);
        mult_d = mul_f(word[`PLLCFG_MUL_MSB:`PLLCFG_MUL_LSB]);
        in_div_sel_d = word[`PLLCFG_IDIV_MSB:`PLLCFG_IDIV_LSB];
        // non-usb parts keep the usb pll bypassed at divide by one
        usb_bypass_d = 1'b1;
        usb_in_div_d = 4'h1;
        if (usb_var_q) begin
            usb_bypass_d = word[`PLLCFG_UBYP_BIT];
            usb_in_div_d = uidiv_f(word[`PLLCFG_UIDIV_MSB:`PLLCFG_UIDIV_LSB]);
        end
        // flag only, the device still runs on a badly programmed word
        rsvd_err_d = captured_q && !rsvd_ok_f(word);
    end

    // ----------------------------------------
    // decoded outputs, one register each
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sys_pll_out_div_o <= `PLLCFG_ODIV_RST;
        end else begin
            sys_pll_out_div_o <= out_div_d;
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sys_pll_mult_o <= `PLLCFG_MUL_RST;
        end else begin
            sys_pll_mult_o <= mult_d;
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sys_pll_in_div_sel_o <= `PLLCFG_IDIV_RST;
        end else begin
            sys_pll_in_div_sel_o <= in_div_sel_d;
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            usb_pll_bypass_o <= `PLLCFG_UBYP_RST;
        end else begin
            usb_pll_bypass_o <= usb_bypass_d;
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            usb_pll_in_div_o <= `PLLCFG_UIDIV_RST;
        end else begin
            usb_pll_in_div_o <= usb_in_div_d;
        end
    end

    // valid one edge after capture, once the decoded registers have settled
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cfg_valid_o <= 1'b0;
        end else begin
            cfg_valid_o <= captured_q;
        end
    end

    // level until the next power-on, there is no clear
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rsvd_err_o <= 1'b0;
        end else begin
            rsvd_err_o <= rsvd_err_d;
        end
    end

    // ----------------------------------------
    // apb read port, writes refused with an error
    // ----------------------------------------
    wire setup;
    reg [31:0] rd_d;
    reg err_d;

    // answer is fixed one cycle after the setup edge, no wait states
    assign setup = psel_i && !penable_i;

    always @* begin
        rd_d = 32'h0000_0000;
        err_d = 1'b0;
        // unmapped offsets read as zero with an error
        case (paddr_i)
            `PLLCFG_OFF_WORD: rd_d = word;
            `PLLCFG_OFF_DEC: rd_d = dec_pack_f(sys_pll_out_div_o, usb_pll_in_div_o,
                                               sys_pll_mult_o, sys_pll_in_div_sel_o);
            `PLLCFG_OFF_STAT: rd_d = stat_pack_f(usb_var_q, usb_pll_bypass_o,
                                                 rsvd_err_o, cfg_valid_o);
            default: err_d = 1'b1;
        endcase
        // the word is fixed until the next power-on, so every write is refused
        if (pwrite_i) begin
            err_d = 1'b1;
            rd_d = 32'h0000_0000;
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup) begin
            prdata_o <= rd_d;
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= setup;
        end
    end

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= setup && err_d;
        end
    end
endmodule // pllcfg_decoder

// file: pllcfg_regs.vh
// pllcfg_regs.vh - constants for the pll configuration word decoder
// assumes inclusion by bare name from the design files
`ifndef PLLCFG_REGS_VH
`define PLLCFG_REGS_VH

// ----------------------------------------
// register offsets (chosen)
// ----------------------------------------
`define PLLCFG_OFF_WORD 12'h000
`define PLLCFG_OFF_DEC 12'h004
`define PLLCFG_OFF_STAT 12'h008

// ----------------------------------------
// field positions
// ----------------------------------------
`define PLLCFG_ODIV_MSB 18
`define PLLCFG_ODIV_LSB 16
`define PLLCFG_UBYP_BIT 15
`define PLLCFG_UIDIV_MSB 10
`define PLLCFG_UIDIV_LSB 8
`define PLLCFG_MUL_MSB 6
`define PLLCFG_MUL_LSB 4
`define PLLCFG_IDIV_MSB 2
`define PLLCFG_IDIV_LSB 0

// reserved bits that must be programmed as one
`define PLLCFG_RSVD_MASK 32'hFFF8_7888

// ----------------------------------------
// reset values
// ----------------------------------------
`define PLLCFG_WORD_RST 32'hFFFF_FFFF
`define PLLCFG_ODIV_RST 9'h100
`define PLLCFG_MUL_RST 5'h18
`define PLLCFG_IDIV_RST 3'h7
`define PLLCFG_UBYP_RST 1'b1
`define PLLCFG_UIDIV_RST 4'hc

`endif

// file: pllcfg_word_store.v
// pllcfg_word_store.v - holds the captured configuration word
// assumes a synchronous reset copy and a one-shot load strobe
`timescale 1ns/10ps
`include "pllcfg_regs.vh"
module pllcfg_word_store (
    // clock and reset
    input wire clk_i,
    input wire rst_b_i,
    // load side
    input wire load_i,
    input wire [31:0] word_i,
    // read side
    output reg [31:0] word_o
);
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            word_o <= `PLLCFG_WORD_RST;
        end else if (load_i) begin
            word_o <= word_i;
        end
    end
endmodule // pllcfg_word_store

// file: tb.sv
// tb.sv - decodes every field code except usb divider code 3 over repeated power-on captures
// assumes pllcfg_decoder and its checker are compiled first
`timescale 1ns/10ps
module tb;
    logic clk_i = 0, rst_b_i = 0, usb_variant_i = 1;
    logic psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] cfg_word_i = 32'hffff_ffff, pwdata_i = 32'h0000_0000, rd, w;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, usb_pll_bypass_o, cfg_valid_o, rsvd_err_o, er, uv, byp, rsv;
    logic [8:0] sys_pll_out_div_o;
    logic [4:0] sys_pll_mult_o;
    logic [2:0] sys_pll_in_div_sel_o;
    logic [3:0] usb_pll_in_div_o;
    logic [8:0] odx;
    logic [4:0] mlx;
    logic [3:0] udx;
    int err_count = 0, checks_done = 0, n;
    always #25 clk_i = ~clk_i;
    pllcfg_decoder uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .usb_variant_i(usb_variant_i),
        .cfg_word_i(cfg_word_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .sys_pll_out_div_o(sys_pll_out_div_o),
        .sys_pll_mult_o(sys_pll_mult_o), .sys_pll_in_div_sel_o(sys_pll_in_div_sel_o),
        .usb_pll_bypass_o(usb_pll_bypass_o), .usb_pll_in_div_o(usb_pll_in_div_o),
        .cfg_valid_o(cfg_valid_o), .rsvd_err_o(rsvd_err_o));
    task test_done;
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            err_count++;
            $display("wrong value %s exp %h got %h", nm, x, s);
        end
    endtask
    // one apb transfer; pready is looked at on rising edges only
    task apb(input logic wr, input logic [11:0] a, output logic [31:0] d, output logic e);
        @(posedge clk_i);
        psel_i <= 1;
        penable_i <= 0;
        pwrite_i <= wr;
        paddr_i <= a;
        @(posedge clk_i);
        penable_i <= 1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            err_count++;
            test_done;
        end
        d = prdata_o;
        e = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    initial begin
        for (int i = 0; i < 8; i++) begin
            uv = (i != 3);
            byp = i[0] | !uv;
            rsv = (i == 5);
            odx = 9'((i == 7) ? 256 : 1 << i);
            mlx = 5'((i == 7) ? 24 : 15 + i);
            udx = 4'(!uv ? 1 : i < 6 ? i + 1 : i == 6 ? 10 : 12);
            // reserved bits all one except bit 31 on pass 5, each three-bit field set to the loop code, bypass to its low bit
            w = 32'hfff8_7888 | (i << 16) | (i[0] << 15);
            w = w | (i << 8) | (i << 4) | i;
            if (rsv) begin
                w[31] = 1'b0;
            end
            @(posedge clk_i);
            rst_b_i <= 0;
            cfg_word_i <= w;
            usb_variant_i <= uv;
            repeat (16) @(posedge clk_i);
            rst_b_i <= 1;
            n = 0;
            while (cfg_valid_o !== 1'b1 && n < 10) begin
                @(posedge clk_i);
                n++;
            end
            if (cfg_valid_o !== 1'b1) begin
                err_count++;
                test_done;
            end
            cfg_word_i <= ~w;
            chk("valid", cfg_valid_o, 1);
            chk("odiv", sys_pll_out_div_o, odx);
            chk("mult", sys_pll_mult_o, mlx);
            chk("idiv", sys_pll_in_div_sel_o, i);
            chk("bypass", usb_pll_bypass_o, byp);
            chk("udiv", usb_pll_in_div_o, udx);
            chk("rsvd", rsvd_err_o, rsv);
            apb(0, 12'h000, rd, er);
            chk("word", rd, w);
            chk("word err", er, 0);
            apb(0, 12'h004, rd, er);
            chk("decoded", rd, {7'h00, odx, 2'b00, udx, 2'b00, mlx, i[2:0]});
            apb(0, 12'h008, rd, er);
            chk("status", rd, {uv, byp, rsv, 1'b1});
            apb(1, 12'h000, rd, er);
            chk("wr err", er, 1);
            apb(0, 12'h00c, rd, er);
            chk("unmapped", rd, 0);
            chk("unmapped err", er, 1);
            apb(0, 12'h000, rd, er);
            chk("held", rd, w);
        end
        test_done;
    end
endmodule // tb
